// ==== fls_pkg.sv ====
package fls_pkg;

    // ------------------------------------------------------------------
    // Default fuse and lock values (0 = programmed, 1 = unprogrammed)
    // ------------------------------------------------------------------
    localparam logic [7:0] EXT_DEFAULT      = 8'hFF;
    localparam logic [7:0] EXT_UNUSED_MASK  = 8'hF8;
    localparam logic [7:0] HIGH_DEFAULT     = 8'h99;
    localparam logic [7:0] LOW_DEFAULT      = 8'h62;
    localparam logic [7:0] LOCK_DEFAULT     = 8'hFF;
    localparam logic [7:0] HIGH_SERIAL_MASK = 8'h20;
    localparam logic [7:0] BYTE_ZERO        = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int HI_EEPROM_PRESERVE_FUSE    = 3;
    localparam int HI_BOOTSZ_T  = 2;
    localparam int HI_BOOTSZ_B  = 1;
    localparam int LO_CLOCK_OUTPUT_FUSE     = 6;
    localparam int LOCK_BOOT_HI = 5;
    localparam int LOCK_BOOT_LO = 4;
    localparam int LOCK_MAIN_1  = 0;

    // ------------------------------------------------------------------
    // Flash and EEPROM address split
    // ------------------------------------------------------------------
    localparam int PC_W        = 15;
    localparam int WORD_TOP    = 6;
    localparam int PAGE_LO     = 7;
    localparam int PAGE_TOP    = 14;
    localparam int EEA_W       = 11;
    localparam int EE_BYTE_TOP = 2;
    localparam int EE_PAGE_LO  = 3;
    localparam int EE_PAGE_TOP = 10;

    // Boot section start per size code; code 0 is the largest section
    localparam logic [14:0] BOOT_START_0 = 15'h7000;
    localparam logic [14:0] BOOT_START_1 = 15'h7800;
    localparam logic [14:0] BOOT_START_2 = 15'h7C00;
    localparam logic [14:0] BOOT_START_3 = 15'h7E00;

    // ------------------------------------------------------------------
    // Programming port selects and boot lock modes
    // ------------------------------------------------------------------
    localparam logic [1:0] SEL_LOW  = 2'h0;
    localparam logic [1:0] SEL_LOCK = 2'h1;
    localparam logic [1:0] SEL_EXT  = 2'h2;
    localparam logic [1:0] SEL_HIGH = 2'h3;
    localparam logic [1:0] SIG_0    = 2'h0;
    localparam logic [1:0] SIG_1    = 2'h1;
    localparam logic [1:0] SIG_2    = 2'h2;
    localparam logic [1:0] BL_OPEN  = 2'h3;

    typedef enum logic [2:0] {
        CMD_NONE   = 3'h0,
        CMD_ERASE  = 3'h1,
        CMD_WR_FUS = 3'h2,
        CMD_WR_LCK = 3'h3,
        CMD_RD_SIG = 3'h4,
        CMD_RD_FUS = 3'h5
    } fls_cmd_t;

    typedef enum logic [2:0] {
        ST_BOOT = 3'h1,
        ST_RUN  = 3'h2,
        ST_PROG = 3'h4
    } fls_state_t;

    function automatic logic fls_in_boot(input logic [14:0] addr, input logic [1:0] sz);
        logic [14:0] start;
        case (sz)
            2'h0:    start = BOOT_START_0;
            2'h1:    start = BOOT_START_1;
            2'h2:    start = BOOT_START_2;
            default: start = BOOT_START_3;
        endcase
        return addr >= start;
    endfunction : fls_in_boot

endpackage : fls_pkg

// ==== fls_guard_if.sv ====
`timescale 1ns/1ps
interface fls_guard_if;
    logic [1:0]  boot_lock;
    logic [1:0]  boot_size;
    logic        vec_in_boot;
    logic [14:0] exec_pc;
    logic [14:0] target_addr;
    logic [10:0] ee_addr;
    logic        target_boot;
    logic        store_ok;
    logic        read_ok;
    logic        irq_block;
    logic [7:0]  page_sel;
    logic [6:0]  word_sel;
    logic [7:0]  ee_page;
    logic [2:0]  ee_byte;

    modport ctl   (output boot_lock, boot_size, vec_in_boot, exec_pc, target_addr, ee_addr,
                   input  target_boot, store_ok, read_ok, irq_block, page_sel, word_sel, ee_page, ee_byte);
    modport guard (input  boot_lock, boot_size, vec_in_boot, exec_pc, target_addr, ee_addr,
                   output target_boot, store_ok, read_ok, irq_block, page_sel, word_sel, ee_page, ee_byte);
endinterface : fls_guard_if

// ==== fls_access_guard.sv ====
`timescale 1ns/1ps
module fls_access_guard (
    fls_guard_if.guard g
);

    logic exec_boot;

    always_comb begin
        exec_boot     = fls_pkg::fls_in_boot(g.exec_pc, g.boot_size);
        g.target_boot = fls_pkg::fls_in_boot(g.target_addr, g.boot_size);
        // Lock field is {hi, lo}; open mode 11 passes everything
        g.store_ok    = 1'b1;
        g.read_ok     = 1'b1;
        g.irq_block   = 1'b0;
        if (g.target_boot && !g.boot_lock[0]) begin
            g.store_ok = 1'b0;
        end
        if (g.target_boot && !exec_boot && !g.boot_lock[1]) begin
            g.read_ok = 1'b0;
        end
        if (exec_boot && !g.vec_in_boot && !g.boot_lock[1]) begin
            g.irq_block = 1'b1;
        end
        g.word_sel = g.target_addr[fls_pkg::WORD_TOP:0];
        g.page_sel = g.target_addr[fls_pkg::PAGE_TOP:fls_pkg::PAGE_LO];
        g.ee_byte  = g.ee_addr[fls_pkg::EE_BYTE_TOP:0];
        g.ee_page  = g.ee_addr[fls_pkg::EE_PAGE_TOP:fls_pkg::EE_PAGE_LO];
    end

endmodule : fls_access_guard

// ==== fls_store.sv ====
`timescale 1ns/1ps
// Behaviour
// - Boot lock 11 leaves stores and reads of the boot section unrestricted.
// - Boot lock 10 or 00 rejects self-program stores into the boot section.
// - Boot lock 00 or 01 denies application-code reads of the boot section.
// - Boot lock 00/01, vectors in application: interrupts off while executing boot code.
// - Fuse bits read 0 when programmed, 1 when unprogrammed.
// - Extended byte bits 7..3 read 1; brown-out bits 2..0 default unprogrammed.
// - High byte defaults: debug off, scan on, serial on, watchdog off, preserve off.
// - Boot size bits default programmed (largest); reset vector bit unprogrammed.
// - Low byte defaults: divide-by-8 on, clock out off, startup 10, source 0010.
// - Serial programming cannot change the serial download enable fuse.
// - Programmed clock output fuse raises the clock output enable, clock_output_en_r.
// - Chip erase leaves all fuse bits unchanged.
// - Fuse changes are refused while the first main lock bit is programmed.
// - Fuses latch on programming entry; changes other than the preserve fuse apply only after leaving.
// - EEPROM preserve fuse takes effect as soon as it is programmed.
// - Fuses are also latched at power-up.
// - Three signature bytes at 0..2, readable even when locked.
// - Calibration byte is copied into the RC calibration register during reset.
// - Flash: word in page is address bits 6..0, page is bits 14..7.
// - EEPROM: byte in page is address bits 2..0, page is bits 10..3.
// - Lock bits only move toward programmed; only chip erase or reset returns them to 1.
// - Chip erase spares EEPROM when the preserve fuse is programmed.
module fls_store #(
    parameter logic [7:0] SIG_BYTE_0 = 8'hA5,   // Identity value is arbitrary
    parameter logic [7:0] SIG_BYTE_1 = 8'h5A,   // Identity value is arbitrary
    parameter logic [7:0] SIG_BYTE_2 = 8'h3C,   // Identity value is arbitrary
    parameter logic [7:0] CAL_BYTE   = 8'h80
) (
    input  wire logic                     mclk,
    input  wire logic                     reset_n,
    input  wire logic                     prog_mode_pin,
    input  wire logic                     prog_serial,
    input  wire logic                     prog_cmd_valid,
    input  wire fls_pkg::fls_cmd_t        prog_cmd,
    input  wire logic [1:0]               prog_addr,
    input  wire logic                     prog_byte_hi,
    input  wire logic [7:0]               prog_wdata,
    output logic [7:0]                    prog_rdata_r,
    output logic                          prog_done_r,
    output logic                          prog_refused_r,
    output logic                          prog_mode_r,
    output logic                          eeprom_erase_r,
    input  wire logic [14:0]              cpu_pc,
    input  wire logic [14:0]              cpu_addr,
    input  wire logic                     vec_in_boot,
    input  wire logic [10:0]              eeprom_address,
    output logic                          store_ok_r,
    output logic                          read_ok_r,
    output logic                          irq_block_r,
    output logic [7:0]                    page_select_bits_r,
    output logic [6:0]                    word_in_page_bits_r,
    output logic [7:0]                    ee_page_r,
    output logic [2:0]                    ee_byte_r,
    output logic [7:0]                    fuse_ext_r,
    output logic [7:0]                    fuse_high_r,
    output logic [7:0]                    fuse_low_r,
    output logic [7:0]                    lock_byte_r,
    output logic                          eeprom_preserve_r,
    output logic                          clock_output_en_r,
    output logic [7:0]                    rc_calibration_register_r
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        fls_pkg::fls_state_t st;
        logic                in_prog;
        logic                sync1;
        logic                sync2;
        logic [7:0]          nv_ext;
        logic [7:0]          nv_high;
        logic [7:0]          nv_low;
        logic [7:0]          nv_lock;
        logic [7:0]          sh_ext;
        logic [7:0]          sh_high;
        logic [7:0]          sh_low;
        logic                eeprom_preserve_fuse;
        logic                clock_output_fuse_en;
        logic [7:0]          cal;
        logic [7:0]          rdata;
        logic                done;
        logic                refused;
        logic                ee_erase;
        logic                store_ok;
        logic                read_ok;
        logic                irq_block;
        logic [7:0]          page_sel;
        logic [6:0]          word_sel;
        logic [7:0]          ee_page;
        logic [2:0]          ee_byte;
    } fls_state_s_t;

    localparam fls_state_s_t RESET_STATE = '{
        st: fls_pkg::ST_BOOT, in_prog: 1'b0, sync1: 1'b0, sync2: 1'b0,
        nv_ext: fls_pkg::EXT_DEFAULT, nv_high: fls_pkg::HIGH_DEFAULT,
        nv_low: fls_pkg::LOW_DEFAULT, nv_lock: fls_pkg::LOCK_DEFAULT,
        sh_ext: fls_pkg::EXT_DEFAULT, sh_high: fls_pkg::HIGH_DEFAULT,
        sh_low: fls_pkg::LOW_DEFAULT, eeprom_preserve_fuse: 1'b0, clock_output_fuse_en: 1'b0,
        cal: CAL_BYTE,
        rdata: fls_pkg::BYTE_ZERO, done: 1'b0, refused: 1'b0, ee_erase: 1'b0,
        store_ok: 1'b1, read_ok: 1'b1, irq_block: 1'b0,
        page_sel: 8'h00, word_sel: 7'h00, ee_page: 8'h00, ee_byte: 3'h0
    };

    fls_state_s_t q_r;
    fls_state_s_t q_nxt;
    fls_guard_if  gi ();

    fls_access_guard u_guard (
        .g (gi.guard)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic [7:0] fuse_wr;
    logic       accept;

    always_comb begin
        q_nxt          = q_r;
        fuse_wr        = prog_wdata;
        accept         = prog_cmd_valid && (q_r.st == fls_pkg::ST_PROG);
        gi.boot_lock   = {q_r.nv_lock[fls_pkg::LOCK_BOOT_HI], q_r.nv_lock[fls_pkg::LOCK_BOOT_LO]};
        gi.boot_size   = {q_r.sh_high[fls_pkg::HI_BOOTSZ_T], q_r.sh_high[fls_pkg::HI_BOOTSZ_B]};
        gi.vec_in_boot = vec_in_boot;
        gi.exec_pc     = cpu_pc;
        gi.target_addr = cpu_addr;
        gi.ee_addr     = eeprom_address;

        // The first stage only feeds the second; metastability stays out of the logic
        q_nxt.sync1    = prog_mode_pin;
        q_nxt.sync2    = q_r.sync1;
        q_nxt.done     = 1'b0;
        q_nxt.refused  = 1'b0;
        q_nxt.ee_erase = 1'b0;

        q_nxt.store_ok  = gi.store_ok;
        q_nxt.read_ok   = gi.read_ok;
        q_nxt.irq_block = gi.irq_block;
        q_nxt.page_sel  = gi.page_sel;
        q_nxt.word_sel  = gi.word_sel;
        q_nxt.ee_page   = gi.ee_page;
        q_nxt.ee_byte   = gi.ee_byte;

        // Preserve fuse bypasses the shadow so an erase in the same session honours it
        q_nxt.eeprom_preserve_fuse   = !q_r.nv_high[fls_pkg::HI_EEPROM_PRESERVE_FUSE];
        q_nxt.clock_output_fuse_en = !q_r.sh_low[fls_pkg::LO_CLOCK_OUTPUT_FUSE];

        case (q_r.st)
            fls_pkg::ST_BOOT: begin
                q_nxt.sh_ext  = q_r.nv_ext;
                q_nxt.sh_high = q_r.nv_high;
                q_nxt.sh_low  = q_r.nv_low;
                q_nxt.st      = fls_pkg::ST_RUN;
            end
            fls_pkg::ST_RUN: begin
                if (q_r.sync2) begin
                    q_nxt.sh_ext  = q_r.nv_ext;
                    q_nxt.sh_high = q_r.nv_high;
                    q_nxt.sh_low  = q_r.nv_low;
                    q_nxt.st      = fls_pkg::ST_PROG;
                end
            end
            fls_pkg::ST_PROG: begin
                if (!q_r.sync2) begin
                    // Fuse changes made in the session reach the shadow only here; lock bits and the preserve fuse act at once
                    q_nxt.sh_ext  = q_r.nv_ext;
                    q_nxt.sh_high = q_r.nv_high;
                    q_nxt.sh_low  = q_r.nv_low;
                    q_nxt.st      = fls_pkg::ST_RUN;
                end
            end
            default: begin
                q_nxt.st = fls_pkg::ST_BOOT;
            end
        endcase
        // Mode flag kept as its own flop so the pin output carries no decode
        q_nxt.in_prog = (q_nxt.st == fls_pkg::ST_PROG);

        if (prog_cmd_valid && !accept) begin
            q_nxt.refused = 1'b1;
        end else if (accept) begin
            q_nxt.done = 1'b1;
            case (prog_cmd)
                fls_pkg::CMD_ERASE: begin
                    // Fuses untouched; lock bits return to unprogrammed
                    q_nxt.nv_lock  = fls_pkg::LOCK_DEFAULT;
                    q_nxt.ee_erase = !q_r.eeprom_preserve_fuse;
                end
                fls_pkg::CMD_WR_FUS: begin
                    if (!q_r.nv_lock[fls_pkg::LOCK_MAIN_1]) begin
                        q_nxt.done    = 1'b0;
                        q_nxt.refused = 1'b1;
                    end else begin
                        case (prog_addr)
                            fls_pkg::SEL_LOW: q_nxt.nv_low = fuse_wr;
                            fls_pkg::SEL_EXT: q_nxt.nv_ext = fuse_wr | fls_pkg::EXT_UNUSED_MASK;
                            fls_pkg::SEL_HIGH: begin
                                if (prog_serial) begin
                                    fuse_wr = (prog_wdata & ~fls_pkg::HIGH_SERIAL_MASK)
                                            | (q_r.nv_high & fls_pkg::HIGH_SERIAL_MASK);
                                end
                                q_nxt.nv_high = fuse_wr;
                            end
                            default: begin
                                q_nxt.done    = 1'b0;
                                q_nxt.refused = 1'b1;
                            end
                        endcase
                    end
                end
                fls_pkg::CMD_WR_LCK: begin
                    q_nxt.nv_lock = q_r.nv_lock & prog_wdata;
                end
                fls_pkg::CMD_RD_SIG: begin
                    // Signature stays readable whatever the lock state
                    case (prog_addr)
                        fls_pkg::SIG_0: q_nxt.rdata = prog_byte_hi ? q_r.cal : SIG_BYTE_0;
                        fls_pkg::SIG_1: q_nxt.rdata = SIG_BYTE_1;
                        fls_pkg::SIG_2: q_nxt.rdata = SIG_BYTE_2;
                        default:        q_nxt.rdata = fls_pkg::BYTE_ZERO;
                    endcase
                end
                fls_pkg::CMD_RD_FUS: begin
                    // Raw stored bits: 0 means programmed
                    case (prog_addr)
                        fls_pkg::SEL_LOW:  q_nxt.rdata = q_r.nv_low;
                        fls_pkg::SEL_LOCK: q_nxt.rdata = q_r.nv_lock;
                        fls_pkg::SEL_EXT:  q_nxt.rdata = q_r.nv_ext;
                        default:           q_nxt.rdata = q_r.nv_high;
                    endcase
                end
                default: begin
                    q_nxt.done    = 1'b0;
                    q_nxt.refused = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            q_r <= RESET_STATE;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prog_rdata_r              = q_r.rdata;
    assign prog_done_r               = q_r.done;
    assign prog_refused_r            = q_r.refused;
    assign prog_mode_r               = q_r.in_prog;
    assign eeprom_erase_r            = q_r.ee_erase;
    assign store_ok_r                = q_r.store_ok;
    assign read_ok_r                 = q_r.read_ok;
    assign irq_block_r               = q_r.irq_block;
    assign page_select_bits_r        = q_r.page_sel;
    assign word_in_page_bits_r       = q_r.word_sel;
    assign ee_page_r                 = q_r.ee_page;
    assign ee_byte_r                 = q_r.ee_byte;
    assign fuse_ext_r                = q_r.sh_ext;
    assign fuse_high_r               = q_r.sh_high;
    assign fuse_low_r                = q_r.sh_low;
    assign lock_byte_r               = q_r.nv_lock;
    assign eeprom_preserve_r         = q_r.eeprom_preserve_fuse;
    assign clock_output_en_r         = q_r.clock_output_fuse_en;
    assign rc_calibration_register_r = q_r.cal;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_open_lock_free: assert property ((gi.boot_lock == fls_pkg::BL_OPEN) |=> (store_ok_r && read_ok_r))
        else $error("open boot lock restricted an access");
    a_boot_store_deny: assert property ((gi.target_boot && !gi.boot_lock[0]) |=> !store_ok_r)
        else $error("store into locked boot section allowed");
    a_boot_read_deny: assert property ((!fls_pkg::fls_in_boot(cpu_pc, gi.boot_size) && gi.target_boot
        && !gi.boot_lock[1]) |=> !read_ok_r)
        else $error("application read of locked boot section allowed");
    a_irq_boot_block: assert property ((fls_pkg::fls_in_boot(cpu_pc, gi.boot_size) && !vec_in_boot
        && !gi.boot_lock[1]) |=> irq_block_r)
        else $error("interrupts not blocked in boot section");
    a_ext_unused_ones: assert property ((q_r.nv_ext & fls_pkg::EXT_UNUSED_MASK) == fls_pkg::EXT_UNUSED_MASK)
        else $error("unused extended bits not one");
    a_serial_keep_dl: assert property ((accept && prog_cmd == fls_pkg::CMD_WR_FUS && prog_serial)
        |=> $stable(q_r.nv_high & fls_pkg::HIGH_SERIAL_MASK))
        else $error("serial write changed download enable");
    a_erase_keep_fuse: assert property ((accept && prog_cmd == fls_pkg::CMD_ERASE)
        |=> ($stable(q_r.nv_high) && $stable(q_r.nv_low) && $stable(q_r.nv_ext)))
        else $error("chip erase changed a fuse");
    a_locked_fuse_hold: assert property ((accept && prog_cmd == fls_pkg::CMD_WR_FUS
        && !lock_byte_r[fls_pkg::LOCK_MAIN_1])
        |=> (prog_refused_r && $stable(q_r.nv_low) && $stable(q_r.nv_high)))
        else $error("fuse changed while main lock set");
    a_prog_shadow_hold: assert property ((prog_mode_r && $past(prog_mode_r) && q_r.sync2)
        |=> $stable(fuse_high_r))
        else $error("shadow fuse moved during programming");
    a_preserve_follow: assert property (##1 (eeprom_preserve_r == !$past(q_r.nv_high[fls_pkg::HI_EEPROM_PRESERVE_FUSE])))
        else $error("preserve fuse not immediate");
    a_powerup_latch: assert property ((q_r.st == fls_pkg::ST_BOOT) |=> (fuse_low_r == $past(q_r.nv_low)))
        else $error("fuses not latched at power-up");
    a_lock_one_way: assert property ((accept && prog_cmd == fls_pkg::CMD_WR_LCK)
        |=> ((lock_byte_r & ~$past(lock_byte_r)) == fls_pkg::BYTE_ZERO))
        else $error("lock bit returned to one without erase");

    c_prog_entry: cover property (q_r.st == fls_pkg::ST_RUN ##1 q_r.st == fls_pkg::ST_PROG);
    c_fuse_write: cover property (accept && prog_cmd == fls_pkg::CMD_WR_FUS ##1 prog_done_r);
    c_store_denied: cover property (!store_ok_r);
    c_erase_spared: cover property (accept && prog_cmd == fls_pkg::CMD_ERASE && eeprom_preserve_r);

endmodule : fls_store

// ==== fls_prog_model.sv ====
`timescale 1ns/1ps
// Programmer side: one-cycle strobe, answer read just after the edge that takes it
module fls_prog_model (
    input  wire logic         mclk,
    input  wire logic         prog_done_r,
    input  wire logic         prog_refused_r,
    input  wire logic [7:0]   prog_rdata_r,
    output fls_pkg::fls_cmd_t prog_cmd = fls_pkg::CMD_NONE,
    output logic              prog_cmd_valid = 1'b0,
    output logic [1:0]        prog_addr = 2'h0,
    output logic              prog_byte_hi = 1'b0,
    output logic [7:0]        prog_wdata = 8'h00
);
    task automatic issue(input fls_pkg::fls_cmd_t c, input logic [1:0] a, input logic hi,
                         input logic [7:0] d, output logic [1:0] ok, output logic [7:0] rd);
        @(posedge mclk);
        prog_cmd_valid <= 1'b1;
        prog_cmd       <= c;
        prog_addr      <= a;
        prog_byte_hi   <= hi;
        prog_wdata     <= d;
        @(posedge mclk);
        prog_cmd_valid <= 1'b0;
        prog_wdata     <= ~d;
        #1;
        ok = {prog_done_r, prog_refused_r};
        rd = prog_rdata_r;
    endtask : issue
endmodule : fls_prog_model

// ==== fuse_lock_signature_store_test.sv ====
`timescale 1ns/1ps
module fuse_lock_signature_store_test;
    logic mclk = 1'b0, reset_n = 1'b0, prog_mode_pin = 1'b0, prog_serial = 1'b0, vec_in_boot = 1'b0;
    logic [14:0] cpu_pc = 15'h0000, cpu_addr = 15'h7000;
    logic [10:0] eeprom_address = 11'h5AB;
    logic [7:0] prog_rdata_r, fuse_ext_r, fuse_high_r, fuse_low_r, lock_byte_r, rc_calibration_register_r;
    logic [7:0] page_select_bits_r, ee_page_r, prog_wdata, rd;
    logic [6:0] word_in_page_bits_r;
    logic [2:0] ee_byte_r;
    logic [1:0] prog_addr;
    logic prog_done_r, prog_refused_r, prog_mode_r, eeprom_erase_r, store_ok_r, read_ok_r, irq_block_r;
    logic eeprom_preserve_r, clock_output_en_r, prog_cmd_valid, prog_byte_hi;
    fls_pkg::fls_cmd_t prog_cmd;
    int error_cnt = 0, n_compared = 0;
    localparam logic [7:0] SIG [3] = '{8'h3E, 8'h71, 8'hC4};  // Identity values are arbitrary
    always #5 mclk = ~mclk;
    fls_store #(.SIG_BYTE_0(SIG[0]), .SIG_BYTE_1(SIG[1]), .SIG_BYTE_2(SIG[2]), .CAL_BYTE(8'h80)) i_fls_store (
        .mclk, .reset_n, .prog_mode_pin, .prog_serial, .prog_cmd_valid, .prog_cmd, .prog_addr, .prog_byte_hi,
        .prog_wdata, .prog_rdata_r, .prog_done_r, .prog_refused_r, .prog_mode_r, .eeprom_erase_r, .cpu_pc,
        .cpu_addr, .vec_in_boot, .eeprom_address, .store_ok_r, .read_ok_r, .irq_block_r, .page_select_bits_r,
        .word_in_page_bits_r, .ee_page_r, .ee_byte_r, .fuse_ext_r, .fuse_high_r, .fuse_low_r, .lock_byte_r,
        .eeprom_preserve_r, .clock_output_en_r, .rc_calibration_register_r);
    fls_prog_model i_fls_prog_model (.mclk, .prog_done_r, .prog_refused_r, .prog_rdata_r, .prog_cmd, .prog_cmd_valid,
        .prog_addr, .prog_byte_hi, .prog_wdata);
    // ------------------------------------------------------------------
    // Shared checks
    // ------------------------------------------------------------------
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic op(fls_pkg::fls_cmd_t c, logic [1:0] a, logic hi, logic [7:0] d, logic ok);
        logic [1:0] g;
        i_fls_prog_model.issue(c, a, hi, d, g, rd);
        chk(g, {ok, !ok});
    endtask : op
    task automatic results;
        if (error_cnt == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    task automatic t_defaults;
        chk(fuse_ext_r, 8'hFF);
        chk(fuse_high_r, 8'h99);
        chk(fuse_low_r, 8'h62);
        chk(rc_calibration_register_r, 8'h80);
        chk({store_ok_r, read_ok_r}, 2'h3);
        chk({page_select_bits_r, word_in_page_bits_r}, 15'h7000);
        chk({ee_page_r, ee_byte_r}, 11'h5AB);
    endtask : t_defaults
    task automatic t_signature;
        @(posedge mclk) prog_mode_pin <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(prog_mode_r, 1'b1);
        for (int i = 0; i < 3; i++) begin
            op(fls_pkg::CMD_RD_SIG, 2'(i), 1'b0, 8'h00, 1'b1);
            chk(rd, SIG[i]);
        end
        op(fls_pkg::CMD_RD_SIG, 2'h0, 1'b1, 8'h00, 1'b1);
        chk(rd, 8'h80);
    endtask : t_signature
    task automatic t_fuses;
        op(fls_pkg::CMD_WR_FUS, 2'h3, 1'b0, 8'h91, 1'b1);
        @(posedge mclk);
        #1;
        chk({eeprom_preserve_r, fuse_high_r}, 9'h199);
        op(fls_pkg::CMD_WR_FUS, 2'h0, 1'b0, 8'h22, 1'b1);
        @(posedge mclk) prog_serial <= 1'b1;
        op(fls_pkg::CMD_WR_FUS, 2'h3, 1'b0, 8'hB1, 1'b1);
        @(posedge mclk) prog_serial <= 1'b0;
        op(fls_pkg::CMD_RD_FUS, 2'h3, 1'b0, 8'h00, 1'b1);
        chk(rd, 8'h91);
        op(fls_pkg::CMD_ERASE, 2'h0, 1'b0, 8'h00, 1'b1);
        chk(eeprom_erase_r, 1'b0);
        op(fls_pkg::CMD_RD_FUS, 2'h0, 1'b0, 8'h00, 1'b1);
        chk(rd, 8'h22);
        op(fls_pkg::CMD_WR_LCK, 2'h1, 1'b0, 8'hCE, 1'b1);
        op(fls_pkg::CMD_WR_LCK, 2'h1, 1'b0, 8'hFF, 1'b1);
        chk(lock_byte_r, 8'hCE);
        op(fls_pkg::CMD_WR_FUS, 2'h2, 1'b0, 8'h00, 1'b0);
        @(posedge mclk) prog_mode_pin <= 1'b0;
        repeat (6) @(posedge mclk);
        #1;
        chk({prog_mode_r, clock_output_en_r, fuse_high_r, fuse_ext_r}, 18'h191FF);
    endtask : t_fuses
    task automatic t_reset;
        @(posedge mclk) reset_n <= 1'b0;
        @(posedge mclk) reset_n <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk({lock_byte_r, fuse_low_r, prog_mode_r}, 17'h1FEC4);
    endtask : t_reset
    task automatic t_core;
        @(posedge mclk) cpu_pc <= 15'h7000;
        repeat (2) @(posedge mclk);
        #1;
        chk({store_ok_r, irq_block_r}, 2'h1);
        @(posedge mclk) cpu_pc <= 15'h0000;
        repeat (2) @(posedge mclk);
        #1;
        chk({read_ok_r, irq_block_r}, 2'h0);
    endtask : t_core
    initial begin
        #200000;
        error_cnt++;
        results();
    end
    initial begin
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        t_defaults();
        t_signature();
        t_fuses();
        t_core();
        t_reset();
        results();
    end
endmodule : fuse_lock_signature_store_test
